// ===== smrc_pkg.sv
// Package for the supply monitor and regulator controller: register map, fields, types
`default_nettype none
package smrc_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   localparam logic [7:0] SUPPLY_COMMAND_REG       = 8'h00;
   localparam logic [7:0] SUPPLY_CONFIGURATION_REG = 8'h04;
   localparam logic [7:0] MONITOR_CONFIGURATION_REG = 8'h08;
   localparam logic [7:0] WAKE_CONFIGURATION_REG   = 8'h0c;
   localparam logic [7:0] SUPPLY_STATUS_REG        = 8'h10;

   // Command register
   localparam int unsigned REGULATOR_OFF_CMD_BIT = 2;
   // Configuration register
   localparam int unsigned REGULATOR_ON_SELECT_BIT = 14;
   localparam int unsigned XTAL_BYPASS_SELECT_BIT  = 20;
   // Monitor configuration register
   localparam int unsigned MONITOR_THRESHOLD_LSB     = 0;
   localparam int unsigned MONITOR_THRESHOLD_W       = 4;
   localparam int unsigned MONITOR_SAMPLE_PERIOD_LSB = 8;
   localparam int unsigned MONITOR_SAMPLE_PERIOD_W   = 2;
   localparam int unsigned MONITOR_RESET_ENABLE_BIT  = 12;
   localparam int unsigned MONITOR_IRQ_ENABLE_BIT    = 13;
   // Wake configuration register
   localparam int unsigned MONITOR_WAKE_ENABLE_BIT = 1;
   // Status register
   localparam int unsigned MONITOR_DETECT_STICKY_BIT = 1;
   localparam int unsigned MONITOR_OUTPUT_LIVE_BIT   = 5;
   localparam int unsigned BACKUP_MODE_BIT           = 8;

   // Threshold code n selects 1900 mV + n * 100 mV
   localparam int unsigned THRESHOLD_BASE_MV = 1900;
   localparam int unsigned THRESHOLD_STEP_MV = 100;

   // Sample period codes and their lengths in slow clock cycles
   typedef enum logic [1:0] {
      SMRC_CONTINUOUS = 2'h0,
      SMRC_EVERY_32   = 2'h1,
      SMRC_EVERY_256  = 2'h2,
      SMRC_EVERY_2048 = 2'h3
   } smrc_period_e;
   localparam int unsigned PERIOD_CNT_W = 11;
   localparam logic [10:0] PERIOD_32_LAST   = 11'h01f;
   localparam logic [10:0] PERIOD_256_LAST  = 11'h0ff;
   localparam logic [10:0] PERIOD_2048_LAST = 11'h7ff;

   typedef struct packed {
      logic               irqEnable;
      logic               resetEnable;
      smrc_period_e       samplePeriod;
      logic [3:0]         threshold;
   } smrc_moncfg_s;

   localparam smrc_moncfg_s MONCFG_RESET = '{irqEnable: 1'b0, resetEnable: 1'b0,
                                              samplePeriod: SMRC_CONTINUOUS, threshold: 4'h0};
endpackage : smrc_pkg
`default_nettype wire

// ===== smrc_sync.sv
// Two flip-flop synchroniser for one asynchronous level
`default_nettype none
module smrc_sync (
   input  wire logic clock,    // Slow clock
   input  wire logic nrst,     // Asynchronous reset, active low
   input  wire logic asyncIn,  // Level from another domain
   output logic      syncOut   // Synchronised level
);
   logic stage1;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stage1  <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule // smrc_sync
`default_nettype wire

// ===== smrc_sampler.sv
// Supply monitor duty cycle timer: one enable cycle per selected period
`default_nettype none
module smrc_sampler (
   input  wire logic                  clock,        // Slow clock
   input  wire logic                  nrst,         // Asynchronous reset, active low
   input  wire smrc_pkg::smrc_period_e period,      // Selected sample period
   output logic                       sampleTick    // High one cycle before the monitor runs
);
   logic [smrc_pkg::PERIOD_CNT_W-1:0] count;
   logic [smrc_pkg::PERIOD_CNT_W-1:0] lastCount;

   always_comb begin
      case (period)
         smrc_pkg::SMRC_EVERY_32:  lastCount = smrc_pkg::PERIOD_32_LAST;
         smrc_pkg::SMRC_EVERY_256: lastCount = smrc_pkg::PERIOD_256_LAST;
         default:                  lastCount = smrc_pkg::PERIOD_2048_LAST;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count      <= '0;
         sampleTick <= 1'b0;
      end else if (period == smrc_pkg::SMRC_CONTINUOUS) begin
         count      <= '0;
         sampleTick <= 1'b1;
      end else begin
         sampleTick <= (count == lastCount);
         if (count >= lastCount) begin
            count <= '0;
         end else begin
            count <= count + 1'b1;
         end
      end
   end
endmodule // smrc_sampler
`default_nettype wire

// ===== smrc_ctrl.sv
// Supply controller: regulator off sequence, regulator select and supply monitor
//
// Our own choices: the placing of the registers and the plain strobed port.
`default_nettype none
module smrc_ctrl (
   input  wire logic                        clock,            // Slow clock, 40 MHz
   input  wire logic                        nrst,             // Asynchronous reset, active low
   input  wire logic [smrc_pkg::ADDR_W-1:0] addr,             // Register byte address
   input  wire logic [smrc_pkg::DATA_W-1:0] writeData,        // Write data
   input  wire logic                        writeStrobe,      // One-cycle write
   input  wire logic                        readStrobe,       // One-cycle read
   output logic      [smrc_pkg::DATA_W-1:0] readData,         // Read data, cycle after strobe
   input  wire logic                        monitorBelow,     // Comparator: rail below threshold
   output logic                             monitorEnable,    // Comparator power enable
   output logic      [3:0]                  monitorThreshold, // Comparator trip level code
   output logic                             regulatorEnable,  // Internal core regulator on
   output logic                             coreDomainResetN, // Core domain reset, active low
   output logic                             coreHalt,         // Stop processor and peripherals
   output logic                             coreWake,         // Core wake-up pulse
   output logic                             xtalBypass,       // Slow crystal bypass select
   output logic                             irq               // Supply controller interrupt
);
   typedef enum logic [1:0] {SMRC_RUN, SMRC_RESYNC, SMRC_HALT, SMRC_BACKUP} smrc_state_e;

   smrc_state_e            state;
   smrc_pkg::smrc_moncfg_s monCfg;
   logic                   regulatorOnSelect;
   logic                   wakeEnable;
   logic                   liveResult;
   logic                   sticky;
   logic                   belowSync;
   logic                   sampleTick;
   logic                   detect;
   logic                   wrCmd;
   logic                   rdStatus;
   logic                   wrStatus;
   logic                   offRequest;
   logic                   measureDly1;
   logic                   measureDly2;

   smrc_sync u_sync (
      .clock   (clock),
      .nrst    (nrst),
      .asyncIn (monitorBelow),
      .syncOut (belowSync)
   );

   smrc_sampler u_sampler (
      .clock      (clock),
      .nrst       (nrst),
      .period     (monCfg.samplePeriod),
      .sampleTick (sampleTick)
   );

   assign wrCmd      = writeStrobe && (addr == smrc_pkg::SUPPLY_COMMAND_REG);
   assign rdStatus   = readStrobe && (addr == smrc_pkg::SUPPLY_STATUS_REG);
   assign wrStatus   = writeStrobe && (addr == smrc_pkg::SUPPLY_STATUS_REG);
   assign offRequest = wrCmd && writeData[smrc_pkg::REGULATOR_OFF_CMD_BIT];
   // Only a result taken while the comparator was powered counts
   assign detect     = measureDly2 && belowSync;

   // Configuration registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         monCfg            <= smrc_pkg::MONCFG_RESET;
         regulatorOnSelect <= 1'b0;
         xtalBypass        <= 1'b0;
         wakeEnable        <= 1'b0;
      end else if (writeStrobe) begin
         if (addr == smrc_pkg::SUPPLY_CONFIGURATION_REG) begin
            regulatorOnSelect <= writeData[smrc_pkg::REGULATOR_ON_SELECT_BIT];
            xtalBypass        <= writeData[smrc_pkg::XTAL_BYPASS_SELECT_BIT];
         end else if (addr == smrc_pkg::MONITOR_CONFIGURATION_REG) begin
            monCfg.threshold    <= writeData[smrc_pkg::MONITOR_THRESHOLD_LSB +: smrc_pkg::MONITOR_THRESHOLD_W];
            monCfg.samplePeriod <= smrc_pkg::smrc_period_e'(
               writeData[smrc_pkg::MONITOR_SAMPLE_PERIOD_LSB +: smrc_pkg::MONITOR_SAMPLE_PERIOD_W]);
            monCfg.resetEnable  <= writeData[smrc_pkg::MONITOR_RESET_ENABLE_BIT];
            monCfg.irqEnable    <= writeData[smrc_pkg::MONITOR_IRQ_ENABLE_BIT];
         end else if (addr == smrc_pkg::WAKE_CONFIGURATION_REG) begin
            wakeEnable <= writeData[smrc_pkg::MONITOR_WAKE_ENABLE_BIT];
         end
      end
   end

   // Regulator off sequence; once off, only a power-on reset leaves backup
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= SMRC_RUN;
      end else begin
         case (state)
            SMRC_RUN: begin
               if (offRequest) begin
                  state <= SMRC_RESYNC;
               end
            end
            SMRC_RESYNC: state <= SMRC_HALT;
            SMRC_HALT:   state <= SMRC_BACKUP;
            default:     state <= SMRC_BACKUP;
         endcase
      end
   end

   // Core control outputs
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         coreDomainResetN <= 1'b1;
         coreHalt         <= 1'b0;
         regulatorEnable  <= 1'b1;
         coreWake         <= 1'b0;
      end else begin
         // Reset low from the cycle after resync on, or one cycle per enabled detection
         coreDomainResetN <= !((state == SMRC_RESYNC) || (state == SMRC_HALT) || (state == SMRC_BACKUP)
                               || (detect && monCfg.resetEnable));
         coreHalt         <= (state != SMRC_RUN);
         // Supply drops one cycle after halt
         regulatorEnable  <= !regulatorOnSelect && (state != SMRC_HALT) && (state != SMRC_BACKUP);
         coreWake         <= detect && wakeEnable;
      end
   end

   // Monitor outputs and status
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         monitorEnable    <= 1'b0;
         monitorThreshold <= 4'h0;
         liveResult       <= 1'b0;
         sticky           <= 1'b0;
         irq              <= 1'b0;
         measureDly1      <= 1'b0;
         measureDly2      <= 1'b0;
      end else begin
         monitorEnable    <= sampleTick;
         monitorThreshold <= monCfg.threshold;
         // Comparator answer of an enabled cycle reaches belowSync two cycles later
         measureDly1      <= monitorEnable;
         measureDly2      <= measureDly1;
         if (measureDly2) begin
            liveResult <= belowSync;
         end
         // A detection in the clearing cycle wins
         if (detect) begin
            sticky <= 1'b1;
         end else if (rdStatus || (wrStatus && writeData[smrc_pkg::MONITOR_DETECT_STICKY_BIT])) begin
            sticky <= 1'b0;
         end
         irq <= (sticky || detect) && monCfg.irqEnable;
      end
   end

   // Read path
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         readData <= '0;
      end else begin
         readData <= '0;
         if (readStrobe) begin
            if (addr == smrc_pkg::SUPPLY_CONFIGURATION_REG) begin
               readData[smrc_pkg::REGULATOR_ON_SELECT_BIT] <= regulatorOnSelect;
               readData[smrc_pkg::XTAL_BYPASS_SELECT_BIT]  <= xtalBypass;
            end else if (addr == smrc_pkg::MONITOR_CONFIGURATION_REG) begin
               readData[smrc_pkg::MONITOR_THRESHOLD_LSB +: smrc_pkg::MONITOR_THRESHOLD_W] <= monCfg.threshold;
               readData[smrc_pkg::MONITOR_SAMPLE_PERIOD_LSB +: smrc_pkg::MONITOR_SAMPLE_PERIOD_W] <=
                  monCfg.samplePeriod;
               readData[smrc_pkg::MONITOR_RESET_ENABLE_BIT] <= monCfg.resetEnable;
               readData[smrc_pkg::MONITOR_IRQ_ENABLE_BIT]   <= monCfg.irqEnable;
            end else if (addr == smrc_pkg::WAKE_CONFIGURATION_REG) begin
               readData[smrc_pkg::MONITOR_WAKE_ENABLE_BIT] <= wakeEnable;
            end else if (addr == smrc_pkg::SUPPLY_STATUS_REG) begin
               readData[smrc_pkg::MONITOR_DETECT_STICKY_BIT] <= sticky;
               readData[smrc_pkg::MONITOR_OUTPUT_LIVE_BIT]   <= liveResult;
               readData[smrc_pkg::BACKUP_MODE_BIT]           <= (state == SMRC_BACKUP);
            end
         end
      end
   end
endmodule // smrc_ctrl
`default_nettype wire

// ===== smrc_ctrl_asserts.sv
// Concurrent checks on the supply controller ports
`default_nettype none
module smrc_ctrl_asserts (
   input wire logic        clock,            // Slow clock
   input wire logic        nrst,             // Reset, active low
   input wire logic [7:0]  addr,             // Address
   input wire logic [31:0] writeData,        // Write data
   input wire logic        writeStrobe,      // Write
   input wire logic        readStrobe,       // Read
   input wire logic [31:0] readData,         // Read data
   input wire logic        monitorBelow,     // Comparator
   input wire logic        monitorEnable,    // Comparator power
   input wire logic [3:0]  monitorThreshold, // Trip code
   input wire logic        regulatorEnable,  // Regulator on
   input wire logic        coreDomainResetN, // Core reset
   input wire logic        coreHalt,         // Core halt
   input wire logic        coreWake,         // Wake pulse
   input wire logic        xtalBypass,       // Bypass
   input wire logic        irq               // Interrupt
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence sOffWrite;
      writeStrobe && addr == 8'h00 && writeData[2];
   endsequence
   sequence sHaltStart;
      !coreHalt ##1 coreHalt;
   endsequence
   chk_off_latency: assert property (sOffWrite |-> ##[1:2] !coreDomainResetN)
      else $error("core reset late after regulator off");
   chk_halt_resets: assert property (sHaltStart |-> !coreDomainResetN)
      else $error("halt without core reset");
   chk_halt_leads_off: assert property (sHaltStart |-> regulatorEnable ##1 !regulatorEnable)
      else $error("supply not removed one cycle after halt");
   chk_halt_cause: assert property (sHaltStart |->
      $past(writeStrobe, 2) && $past(addr, 2) == 8'h00 && $past(writeData[2], 2))
      else $error("halt without regulator off command");
   chk_backup_holds: assert property (coreHalt && !regulatorEnable |=> coreHalt && !regulatorEnable)
      else $error("backup mode left");
   chk_read_idle: assert property (!$past(readStrobe) |-> readData == 32'h0)
      else $error("read data outside read cycle");
   chk_thr_follows: assert property (writeStrobe && addr == 8'h08 |-> ##2 monitorThreshold == $past(writeData[3:0], 2))
      else $error("threshold not taken");
   chk_bypass_follows: assert property (writeStrobe && addr == 8'h04 |=> xtalBypass == $past(writeData[20]))
      else $error("bypass select not taken");
   chk_ext_supply: assert property (writeStrobe && addr == 8'h04 && writeData[14] |-> ##[1:2] !regulatorEnable)
      else $error("regulator still on with external supply");
endmodule // smrc_ctrl_asserts
bind smrc_ctrl smrc_ctrl_asserts i_smrc_ctrl_asserts (.clock(clock), .nrst(nrst), .addr(addr),
   .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
   .monitorBelow(monitorBelow), .monitorEnable(monitorEnable), .monitorThreshold(monitorThreshold),
   .regulatorEnable(regulatorEnable), .coreDomainResetN(coreDomainResetN), .coreHalt(coreHalt),
   .coreWake(coreWake), .xtalBypass(xtalBypass), .irq(irq));
`default_nettype wire

// ===== smrc_comparator_model.sv
// Behavioural supply monitor comparator on the io supply rail
`default_nettype none
module smrc_comparator_model (
   input  wire logic       clock,     // Slow clock
   input  wire logic       enable,    // Comparator powered
   input  wire logic [3:0] threshold, // Trip level code
   input  var  int         railMv,    // Rail level in mV
   output logic            below      // Rail under trip level
);
   timeunit 1ns;
   timeprecision 1ps;
   int   tripMv;
   logic junk = 1'b0;
   assign tripMv = 1900 + 100 * int'(threshold);
   always @(posedge clock) junk <= ~junk;
   // Unpowered comparator gives no usable answer
   assign below = enable ? (railMv < tripMv) : junk;
endmodule // smrc_comparator_model
`default_nettype wire

// ===== supply_monitor_regulator_ctrl_bench.sv
// Self-checking bench for the supply controller
`default_nettype none
module supply_monitor_regulator_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q;} smrc_row_s;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] writeData = 32'h0;
   logic        writeStrobe = 1'b0;
   logic        readStrobe = 1'b0;
   logic [31:0] readData;
   logic [3:0]  monitorThreshold;
   logic        monitorBelow, monitorEnable, regulatorEnable, coreDomainResetN, coreHalt, coreWake, xtalBypass, irq;
   int          railMv = 2550;
   int          nErrors = 0, checkCount = 0, nWake = 0, nRstLow = 0, n0, r0, sp;
   smrc_row_s   rows[7] = '{{8'h04, 32'h00100000, 32'h00100000}, {8'h04, 32'h0, 32'h0}, {8'h0c, 32'h2, 32'h2},
                            {8'h08, 32'hf, 32'hf}, {8'h00, 32'h0, 32'h0}, {8'h20, 32'hffffffff, 32'h0},
                            {8'h08, 32'h0, 32'h0}};
   smrc_ctrl i_smrc_ctrl (.clock(clock), .nrst(nrst), .addr(addr), .writeData(writeData), .writeStrobe(writeStrobe),
      .readStrobe(readStrobe), .readData(readData), .monitorBelow(monitorBelow), .monitorEnable(monitorEnable),
      .monitorThreshold(monitorThreshold), .regulatorEnable(regulatorEnable), .coreDomainResetN(coreDomainResetN),
      .coreHalt(coreHalt), .coreWake(coreWake), .xtalBypass(xtalBypass), .irq(irq));
   smrc_comparator_model i_smrc_comparator_model (.clock(clock), .enable(monitorEnable),
      .threshold(monitorThreshold), .railMv(railMv), .below(monitorBelow));
   initial begin
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (coreWake === 1'b1) nWake++;
      if (coreDomainResetN === 1'b0) nRstLow++;
   end
   task automatic cyc(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         nErrors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      addr <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      cyc(1);
      writeStrobe <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(string what, logic [7:0] a, logic [31:0] exp);
      addr <= a;
      readStrobe <= 1'b1;
      cyc(1);
      readStrobe <= 1'b0;
      chk(what, exp, readData);
      cyc(1);
   endtask
   task automatic nextEn(output int n);
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (monitorEnable !== 1'b1 && n < 5000);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clock);
      nErrors++;
      summarize();
   end
   initial begin
      cyc(5);
      chk("reset outputs", 32'h300, {22'h0, regulatorEnable, coreDomainResetN, coreHalt, coreWake, irq, xtalBypass,
         monitorThreshold});
      chk("reset readData", 32'h0, readData);
      nrst <= 1'b1;
      cyc(1);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd("readback", rows[i].a, rows[i].q);
         chk("core state", 32'h3, {30'h0, regulatorEnable, coreDomainResetN});
      end
      wr(8'h04, 32'h00004000);
      chk("external supply", 32'h0, {31'h0, regulatorEnable});
      wr(8'h04, 32'h0);
      chk("internal supply", 32'h1, {31'h0, regulatorEnable});
      for (int c = 1; c < 4; c++) begin
         wr(8'h08, 32'(c) << 8);
         nextEn(sp);
         nextEn(sp);
         nextEn(sp);
         chk("sample period", 32'd32 << (3 * (c - 1)), 32'(sp));
      end
      wr(8'h08, 32'h3006);
      wr(8'h10, 32'h2);
      rd("status above trip", 8'h10, 32'h0);
      n0 = nWake;
      r0 = nRstLow;
      wr(8'h08, 32'h3007);
      cyc(8);
      chk("wake", 32'h1, {31'h0, nWake > n0});
      chk("core reset", 32'h1, {31'h0, nRstLow > r0});
      chk("irq raised", 32'h1, {31'h0, irq});
      rd("status below trip", 8'h10, 32'h22);
      railMv = 3300;
      cyc(6);
      rd("status sticky", 8'h10, 32'h02);
      rd("status cleared", 8'h10, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(8'h08, 32'h0007);
      railMv = 2550;
      cyc(6);
      chk("irq masked", 32'h0, {31'h0, irq});
      railMv = 3300;
      cyc(4);
      wr(8'h08, 32'h2007);
      cyc(2);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(8'h10, 32'h2);
      cyc(2);
      chk("irq after clear", 32'h0, {31'h0, irq});
      wr(8'h00, 32'h4);
      cyc(2);
      chk("backup outputs", 32'h4, {29'h0, coreHalt, coreDomainResetN, regulatorEnable});
      rd("status backup", 8'h10, 32'h100);
      nrst <= 1'b0;
      cyc(2);
      chk("reset in backup", 32'h3, {29'h0, coreHalt, coreDomainResetN, regulatorEnable});
      nrst <= 1'b1;
      cyc(2);
      chk("after backup reset", 32'h3, {29'h0, coreHalt, coreDomainResetN, regulatorEnable});
      rd("status after reset", 8'h10, 32'h0);
      summarize();
   end
endmodule // supply_monitor_regulator_ctrl_bench
`default_nettype wire
